// ===== design/sec_check.sv
// closing permission: energizing check, synchrocheck, command sequence
`default_nettype none
//
// Contract
// - enable setting switches function; disabled grants nothing
// - passed energizing check alone permits closing
// - swap setting exchanges bus and line inputs first
// - dead and live per side from separate thresholds
// - seven energizing direction selections
// - energizing condition must hold for energizing time; lapse restarts timer
// - no energizing permit when live side exceeds max energizing voltage
// - four energized outputs, at most one active
// - state unknown while any voltage sits between thresholds
// - synchrocheck needs both sides live
// - synchrocheck needs both frequencies within 95..105 percent rated
// - synchrocheck needs both voltages below max energizing voltage
// - synchronous mode: slip below 0.1 percent, angle near zero
// - synchronous mode: voltage difference at most 1 percent rated
// - asynchronous mode: voltage difference below its limit
// - asynchronous mode: angle difference below angle limit
// - asynchronous mode: frequency difference below its limit
// - asynchronous mode: closing angle below angle limit
// - sync conditions must persist for breaker closing time
// - block input inhibits outputs and holds timers
// - continuous mode: permit follows conditions, request ignored
// - command mode: one close pulse per request, only inside window
// - window expiry without closing gives a 500 ms alarm pulse
// - bypass input or both checks disabled: conditions always met
module sec_check import sec_pkg::*; (
  // clock, reset, enables
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic tick_ms_i,
  // settings
  input wire logic enable_i,
  input wire logic swap_src_i,
  input wire sec_ld_mode_t ld_mode_i,
  input wire sec_sync_mode_t sync_mode_i,
  input wire sec_ctl_mode_t ctl_mode_i,
  input wire logic [MAG_W-1:0] dead_bus_i,
  input wire logic [MAG_W-1:0] dead_line_i,
  input wire logic [MAG_W-1:0] live_bus_i,
  input wire logic [MAG_W-1:0] live_line_i,
  input wire logic [MAG_W-1:0] max_energ_v_i,
  input wire logic [MAG_W-1:0] diff_v_i,
  input wire logic [ANG_W-1:0] diff_ang_i,
  input wire logic [FRQ_W-1:0] diff_freq_i,
  input wire logic [FRQ_W-1:0] rated_freq_i,
  input wire logic [MAG_W-1:0] rated_volt_i,
  input wire logic [TMR_W-1:0] energ_time_i,
  input wire logic [TMR_W-1:0] cb_close_time_i,
  input wire logic [TMR_W-1:0] max_syn_time_i,
  input wire logic [TMR_W-1:0] close_pulse_i,
  // measurements
  input wire logic [MAG_W-1:0] v_bus_i,
  input wire logic [MAG_W-1:0] v_line_i,
  input wire logic [FRQ_W-1:0] f_bus_i,
  input wire logic [FRQ_W-1:0] f_line_i,
  input wire logic signed [ANG_W-1:0] ph_bus_i,
  input wire logic signed [ANG_W-1:0] ph_line_i,
  // control
  input wire logic close_request_in_i,
  input wire logic bypass_i,
  input wire logic block_i,
  // results
  output logic sync_ok_o,
  output logic close_sequence_active_o,
  output logic close_failed_alarm_o,
  output logic request_stuck_alarm_o,
  output logic feeder_live_bus_dead_o,
  output logic both_sides_live_o,
  output logic feeder_dead_bus_live_o,
  output logic both_sides_dead_o,
  output sec_energ_t energized_state_o
);
  // ********************
  // reset release
  // ********************
  logic [1:0] rst_sync;
  logic rst_n;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ********************
  // side selection
  // ********************
  logic [MAG_W-1:0] vb, vl;
  logic [FRQ_W-1:0] fb, fl;
  logic signed [ANG_W-1:0] pb, pl;

  always_comb begin
    vb = swap_src_i ? v_line_i : v_bus_i;
    vl = swap_src_i ? v_bus_i : v_line_i;
    fb = swap_src_i ? f_line_i : f_bus_i;
    fl = swap_src_i ? f_bus_i : f_line_i;
    pb = swap_src_i ? ph_line_i : ph_bus_i;
    pl = swap_src_i ? ph_bus_i : ph_line_i;
  end

  // ********************
  // energized state
  // ********************
  logic bus_dead, bus_live, line_dead, line_live;
  sec_energ_t next_energ;

  assign bus_dead = vb < dead_bus_i;
  assign bus_live = vb > live_bus_i;
  assign line_dead = vl < dead_line_i;
  assign line_live = vl > live_line_i;

  always_comb begin
    next_energ = EN_UNKNOWN;
    if (bus_dead && line_dead) begin
      next_energ = EN_BOTH_DEAD;
    end else if (bus_dead && line_live) begin
      next_energ = EN_FEEDER_LIVE_BUS_DEAD;
    end else if (bus_live && line_live) begin
      next_energ = EN_BOTH_SIDES_LIVE;
    end else if (bus_live && line_dead) begin
      next_energ = EN_FEEDER_DEAD_BUS_LIVE;
    end
  end

  // ********************
  // energizing check
  // ********************
  logic ld_match, live_v_ok, energ_cond, energ_pass;

  always_comb begin
    case (ld_mode_i)
      LD_BOTH_DEAD: ld_match = bus_dead && line_dead;
      LD_LIVE_L_DEAD_B: ld_match = bus_dead && line_live;
      LD_DEAD_L_LIVE_B: ld_match = line_dead && bus_live;
      LD_DEAD_B_L_ANY: ld_match = bus_dead && (line_dead || line_live);
      LD_DEAD_L_B_ANY: ld_match = line_dead && (bus_dead || bus_live);
      LD_ONE_LIVE: ld_match = (bus_dead && line_live) || (line_dead && bus_live);
      LD_NOT_BOTH_LIVE: ld_match = (bus_dead || line_dead) &&
                                   (bus_dead || bus_live) && (line_dead || line_live);
      default: ld_match = 1'b0;
    endcase
  end

  // only the live side is held to the ceiling; a dead side is low anyway
  assign live_v_ok = (!bus_live || vb <= max_energ_v_i) &&
                     (!line_live || vl <= max_energ_v_i);
  assign energ_cond = ld_match && live_v_ok;

  // ********************
  // synchrocheck
  // ********************
  localparam int WW = 48;
  logic signed [WW-1:0] dphi_raw, dphi, fdiff, vdiff, slip, cang;
  logic [WW-1:0] adphi, afd, avd, acang;
  logic f_ok, sync_cond, mode_ok, sync_conf;

  function automatic logic in_band(input logic [FRQ_W-1:0] f);
    logic [WW-1:0] fs, ns;
    fs = WW'(f) * WW'(PCT_SCALE);
    ns = WW'(rated_freq_i);
    in_band = fs >= ns * WW'(FREQ_LO_PCT) && fs <= ns * WW'(FREQ_HI_PCT);
  endfunction

  function automatic logic [WW-1:0] mag(input logic signed [WW-1:0] x);
    mag = x < 0 ? WW'(-x) : WW'(x);
  endfunction

  always_comb begin
    dphi_raw = WW'(pb) - WW'(pl);
    // fold into half a turn so a wrap at 180 degrees is not a big error
    if (dphi_raw > WW'(ANG_HALF)) begin
      dphi = dphi_raw - WW'(ANG_FULL);
    end else if (dphi_raw < -WW'(ANG_HALF)) begin
      dphi = dphi_raw + WW'(ANG_FULL);
    end else begin
      dphi = dphi_raw;
    end
    fdiff = $signed(WW'(fb)) - $signed(WW'(fl));
    vdiff = $signed(WW'(vb)) - $signed(WW'(vl));
    slip = fdiff * $signed(WW'(cb_close_time_i)) * $signed(WW'(CA_NUM));
    cang = dphi + slip / $signed(WW'(CA_DEN));
    adphi = mag(dphi);
    afd = mag(fdiff);
    avd = mag(vdiff);
    acang = mag(cang);
  end

  assign f_ok = in_band(fb) && in_band(fl);

  always_comb begin
    case (sync_mode_i)
      SM_SYNC: mode_ok = afd * WW'(MILLE_SCALE) <
                         WW'(rated_freq_i) * WW'(SLIP_PER_MILLE) &&
                         acang <= WW'(SYNC_ANG_WIN) &&
                         avd * WW'(PCT_SCALE) <=
                         WW'(rated_volt_i) * WW'(VDIFF_PCT);
      SM_ASYNC: mode_ok = avd < WW'(diff_v_i) &&
                          adphi < WW'(diff_ang_i) &&
                          afd < WW'(diff_freq_i) &&
                          acang < WW'(diff_ang_i);
      default: mode_ok = 1'b0;
    endcase
  end

  assign sync_cond = bus_live && line_live && f_ok &&
                     vb < max_energ_v_i && vl < max_energ_v_i &&
                     mode_ok;

  // ********************
  // timers
  // ********************
  sec_tmr_if tif[TI_NUM] ();

  for (genvar i = 0; i < TI_NUM; i++) begin : g_tmr
    sec_timer u_tmr (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .ce_i(ce_i),
      .tick_i(tick_ms_i),
      .t(tif[i])
    );
    assign tif[i].hold = block_i;
  end

  // ********************
  // permission
  // ********************
  logic bypass, permit;

  assign tif[TI_ENERG].run = energ_cond;
  assign tif[TI_ENERG].limit = energ_time_i;
  assign energ_pass = tif[TI_ENERG].done;
  assign tif[TI_SYNC].run = sync_cond;
  assign tif[TI_SYNC].limit = cb_close_time_i;
  assign sync_conf = tif[TI_SYNC].done;
  assign bypass = bypass_i || (ld_mode_i == LD_DISABLE && sync_mode_i == SM_DISABLE);
  assign permit = enable_i && (bypass || energ_pass || sync_conf);

  // ********************
  // command sequence
  // ********************
  sec_cmd_st_t st, next_st;
  logic req_q, req_rise, alarm_run, cmd_mode;

  assign cmd_mode = ctl_mode_i == CM_COMMAND;
  assign req_rise = close_request_in_i && !req_q;
  assign tif[TI_WIN].run = st == CS_WAIT;
  assign tif[TI_WIN].limit = max_syn_time_i;
  assign tif[TI_PULSE].run = st == CS_PULSE;
  assign tif[TI_PULSE].limit = close_pulse_i;
  assign tif[TI_ALARM].run = alarm_run;
  assign tif[TI_ALARM].limit = TMR_W'(ALARM_MS);
  assign tif[TI_STUCK].run = cmd_mode && enable_i && close_request_in_i;
  assign tif[TI_STUCK].limit = max_syn_time_i + TMR_W'(STUCK_EXTRA_MS);

  always_comb begin
    next_st = st;
    case (st)
      CS_IDLE: if (cmd_mode && enable_i && req_rise) next_st = CS_WAIT;
      CS_WAIT: begin
        if (!close_request_in_i) begin
          next_st = CS_IDLE;
        end else if (tif[TI_WIN].done) begin
          next_st = CS_DONE;
        end else if (permit) begin
          next_st = CS_PULSE;
        end
      end
      CS_PULSE: if (tif[TI_PULSE].done) next_st = CS_DONE;
      CS_DONE: if (!close_request_in_i) next_st = CS_IDLE;
      default: next_st = CS_IDLE;
    endcase
  end

  // blocked sequence freezes where it stands, like its timers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= CS_IDLE;
      req_q <= 1'b0;
    end else if (ce_i && !block_i) begin
      st <= next_st;
      req_q <= close_request_in_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      alarm_run <= 1'b0;
    end else if (ce_i && !block_i) begin
      if (st == CS_WAIT && next_st == CS_DONE) begin
        alarm_run <= 1'b1;
      end else if (tif[TI_ALARM].done) begin
        alarm_run <= 1'b0;
      end
    end
  end

  // ********************
  // outputs
  // ********************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync_ok_o <= 1'b0;
      close_sequence_active_o <= 1'b0;
      close_failed_alarm_o <= 1'b0;
      request_stuck_alarm_o <= 1'b0;
      energized_state_o <= EN_UNKNOWN;
    end else if (ce_i) begin
      if (block_i || !enable_i) begin
        sync_ok_o <= 1'b0;
        close_sequence_active_o <= 1'b0;
        close_failed_alarm_o <= 1'b0;
        request_stuck_alarm_o <= 1'b0;
        energized_state_o <= EN_UNKNOWN;
      end else begin
        sync_ok_o <= cmd_mode ? (next_st == CS_PULSE) : permit;
        close_sequence_active_o <= next_st == CS_WAIT;
        close_failed_alarm_o <= alarm_run && !tif[TI_ALARM].done;
        request_stuck_alarm_o <= tif[TI_STUCK].done;
        energized_state_o <= next_energ;
      end
    end
  end

  assign feeder_live_bus_dead_o = energized_state_o == EN_FEEDER_LIVE_BUS_DEAD;
  assign both_sides_live_o = energized_state_o == EN_BOTH_SIDES_LIVE;
  assign feeder_dead_bus_live_o = energized_state_o == EN_FEEDER_DEAD_BUS_LIVE;
  assign both_sides_dead_o = energized_state_o == EN_BOTH_DEAD;

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  one_hot_a: assert property ($onehot0({feeder_live_bus_dead_o, both_sides_live_o,
    feeder_dead_bus_live_o, both_sides_dead_o})) else $error("energized outputs overlap");
  disabled_a: assert property (ce_i && !enable_i |=> !sync_ok_o)
    else $error("permit while disabled");
  block_out_a: assert property (ce_i && block_i |=> !sync_ok_o && !close_failed_alarm_o)
    else $error("outputs active while blocked");
  unknown_a: assert property (ce_i && enable_i && !block_i && !bus_dead && !bus_live
    |=> energized_state_o == EN_UNKNOWN) else $error("state not unknown");
  energ_volt_a: assert property (ce_i && enable_i && !block_i && !cmd_mode &&
    !bypass_i && ld_mode_i != LD_DISABLE && sync_mode_i == SM_DISABLE &&
    ((bus_live && vb > max_energ_v_i) || (line_live && vl > max_energ_v_i))
    |=> !sync_ok_o) else $error("energizing permit over voltage ceiling");
  sync_live_a: assert property (ce_i && enable_i && !block_i && !cmd_mode &&
    !bypass_i && ld_mode_i == LD_DISABLE && sync_mode_i != SM_DISABLE &&
    !(bus_live && line_live) |=> !sync_ok_o) else $error("sync permit without both live");
  cont_mode_a: assert property (ce_i && !cmd_mode && !permit |=> !sync_ok_o)
    else $error("continuous permit without conditions");
  cancel_a: assert property (ce_i && !block_i && st == CS_WAIT && !close_request_in_i
    |=> st == CS_IDLE && !close_sequence_active_o) else $error("sequence not cancelled");
  fail_a: assert property ($rose(alarm_run) |-> $past(st) == CS_WAIT)
    else $error("alarm outside window expiry");
  bypass_a: assert property (enable_i && bypass_i |-> permit)
    else $error("bypass did not permit");
endmodule // sec_check
`default_nettype wire

// ===== design/sec_pkg.sv
// shared constants and types of the sync and energize check block
`default_nettype none
package sec_pkg;
  // ********************
  // widths and scales
  // ********************
  localparam int MAG_W = 16;
  localparam int FRQ_W = 20;
  localparam int ANG_W = 13;
  localparam int TMR_W = 18;
  localparam int PCT_SCALE = 100;
  localparam int FREQ_LO_PCT = 95;
  localparam int FREQ_HI_PCT = 105;
  localparam int MILLE_SCALE = 1000;
  localparam int SLIP_PER_MILLE = 1;
  localparam int VDIFF_PCT = 1;
  localparam int ANG_HALF = 1800;
  localparam int ANG_FULL = 3600;
  localparam int SYNC_ANG_WIN = 50;
  localparam int CA_NUM = 36;
  localparam int CA_DEN = 10000;
  // ********************
  // timing in ms ticks
  // ********************
  localparam int ALARM_MS = 500;
  localparam int STUCK_EXTRA_MS = 5000;
  // ********************
  // timer slots
  // ********************
  localparam int TI_ENERG = 0;
  localparam int TI_SYNC = 1;
  localparam int TI_WIN = 2;
  localparam int TI_PULSE = 3;
  localparam int TI_ALARM = 4;
  localparam int TI_STUCK = 5;
  localparam int TI_NUM = 6;
  // ********************
  // modes and states
  // ********************
  typedef enum logic [2:0] {
    LD_DISABLE, LD_BOTH_DEAD, LD_LIVE_L_DEAD_B, LD_DEAD_L_LIVE_B,
    LD_DEAD_B_L_ANY, LD_DEAD_L_B_ANY, LD_ONE_LIVE, LD_NOT_BOTH_LIVE
  } sec_ld_mode_t;
  typedef enum logic [1:0] {SM_DISABLE, SM_SYNC, SM_ASYNC} sec_sync_mode_t;
  typedef enum logic {CM_CONTINUOUS, CM_COMMAND} sec_ctl_mode_t;
  typedef enum logic [2:0] {
    EN_UNKNOWN, EN_BOTH_DEAD, EN_FEEDER_LIVE_BUS_DEAD, EN_BOTH_SIDES_LIVE, EN_FEEDER_DEAD_BUS_LIVE
  } sec_energ_t;
  typedef enum logic [1:0] {CS_IDLE, CS_WAIT, CS_PULSE, CS_DONE} sec_cmd_st_t;
endpackage
`default_nettype wire

// ===== design/sec_tmr_if.sv
// control and status of one millisecond timer
`default_nettype none
interface sec_tmr_if import sec_pkg::*; ();
  logic run;
  logic hold;
  logic [TMR_W-1:0] limit;
  logic done;
  modport ctl (output run, output hold, output limit, input done);
  modport tmr (input run, input hold, input limit, output done);
endinterface
`default_nettype wire

// ===== design/sec_timer.sv
// millisecond timer that restarts whenever its run level drops
`default_nettype none
module sec_timer import sec_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic tick_i,
  // control
  sec_tmr_if.tmr t
);
  logic [TMR_W-1:0] count;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (ce_i) begin
      if (!t.run) begin
        count <= '0;
      end else if (tick_i && !t.hold && count < t.limit) begin
        count <= count + 1'b1;
      end
    end
  end

  assign t.done = t.run && (count >= t.limit);
endmodule // sec_timer
`default_nettype wire

// ===== test/sec_ctl_model.sv
// breaker control partner: holds a close request and watches the answers
`default_nettype none
module sec_ctl_model (
  // clock and start
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [15:0] hold_i,
  // answers from the check block
  input wire logic sync_ok_i,
  input wire logic alarm_i,
  input wire logic stuck_i,
  // request and observations
  output logic req_o,
  output logic [7:0] pulses_o,
  output logic alarm_seen_o,
  output logic stuck_seen_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] left = 16'h0000;
  logic ok_q = 1'b0;
  initial begin
    req_o = 1'b0;
    pulses_o = 8'h00;
    alarm_seen_o = 1'b0;
    stuck_seen_o = 1'b0;
  end
  // ********************
  // request sequencing
  // ********************
  always @(posedge clk_i) begin
    ok_q <= sync_ok_i;
    if (sync_ok_i && !ok_q) pulses_o <= pulses_o + 8'h01;
    if (alarm_i) alarm_seen_o <= 1'b1;
    if (stuck_i) stuck_seen_o <= 1'b1;
    // request kept up for hold_i cycles after start, then dropped, even while the window still runs
    if (start_i) begin
      req_o <= 1'b1;
      left <= hold_i;
      pulses_o <= 8'h00;
      alarm_seen_o <= 1'b0;
      stuck_seen_o <= 1'b0;
    end else if (left != 16'h0000) left <= left - 16'h0001;
    else req_o <= 1'b0;
  end
endmodule // sec_ctl_model
`default_nettype wire

// ===== test/test_sync_energize_check.sv
// self-checking bench for the sync and energize check block
`default_nettype none
module test_sync_energize_check import sec_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int id; logic [7:0] exp;} sec_note_t;
  localparam logic [15:0] v_dead = 16'h0014;
  localparam logic [15:0] v_live = 16'h03e8;
  localparam logic [19:0] f_nom = 20'h0_c350;
  logic clk_i = 1'b0, arst_n_i = 1'b0, tick = 1'b1, en = 1'b1, swap = 1'b0;
  logic byp = 1'b0, blk = 1'b0, start = 1'b0, req;
  sec_ld_mode_t ld = LD_DISABLE;
  sec_sync_mode_t sm = SM_DISABLE;
  sec_ctl_mode_t cm = CM_CONTINUOUS;
  logic [MAG_W-1:0] vb = 16'h0000, vl = 16'h0000;
  logic [FRQ_W-1:0] fl = 20'h0_c350;
  logic signed [ANG_W-1:0] pl = 13'h0000;
  logic [15:0] hold = 16'h0028;
  logic ce = 1'b1;
  logic [MAG_W-1:0] dead_b = 16'h0064, dead_l = 16'h0064, live_b = 16'h01f4, live_l = 16'h01f4;
  logic [MAG_W-1:0] vmax = 16'h07d0, dv = 16'h0064, vn = 16'h03e8;
  logic [ANG_W-1:0] dang = 13'h0064;
  logic signed [ANG_W-1:0] pb = 13'h0000;
  logic [FRQ_W-1:0] dfreq = 20'h0_0064, fn = 20'h0_c350, fb = 20'h0_c350;
  logic [TMR_W-1:0] t_en = 18'h0_0003, t_cb = 18'h0_0002, t_win = 18'h0_0014, t_pl = 18'h0_0004;
  logic ok_o, act_o, fail_o, stuck_o, feeder_live_bus_dead, both_sides_live, feeder_dead_bus_live, both_sides_dead, al_seen, st_seen;
  logic [7:0] pulses;
  sec_energ_t st_o;
  sec_note_t q[$];
  event look;
  int failures = 0, samples_checked = 0, seed = 96;
  initial forever #10 clk_i = ~clk_i;
  sec_check uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .tick_ms_i(tick),
    .enable_i(en), .swap_src_i(swap), .ld_mode_i(ld), .sync_mode_i(sm), .ctl_mode_i(cm),
    .dead_bus_i(dead_b), .dead_line_i(dead_l), .live_bus_i(live_b),
    .live_line_i(live_l), .max_energ_v_i(vmax), .diff_v_i(dv),
    .diff_ang_i(dang), .diff_freq_i(dfreq), .rated_freq_i(fn),
    .rated_volt_i(vn), .energ_time_i(t_en), .cb_close_time_i(t_cb),
    .max_syn_time_i(t_win), .close_pulse_i(t_pl), .v_bus_i(vb), .v_line_i(vl),
    .f_bus_i(fb), .f_line_i(fl), .ph_bus_i(pb), .ph_line_i(pl),
    .close_request_in_i(req), .bypass_i(byp), .block_i(blk), .sync_ok_o(ok_o),
    .close_sequence_active_o(act_o), .close_failed_alarm_o(fail_o),
    .request_stuck_alarm_o(stuck_o), .feeder_live_bus_dead_o(feeder_live_bus_dead), .both_sides_live_o(both_sides_live),
    .feeder_dead_bus_live_o(feeder_dead_bus_live), .both_sides_dead_o(both_sides_dead), .energized_state_o(st_o));
  sec_ctl_model ctl (.clk_i(clk_i), .start_i(start), .hold_i(hold), .sync_ok_i(ok_o),
    .alarm_i(fail_o), .stuck_i(stuck_o), .req_o(req), .pulses_o(pulses),
    .alarm_seen_o(al_seen), .stuck_seen_o(st_seen));
  // ********************
  // shared tasks
  // ********************
  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic note(int id, logic [7:0] exp);
    q.push_back('{id, exp});
    -> look;
    #1;
  endtask
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic row(sec_ld_mode_t l, sec_sync_mode_t s, logic [15:0] b, logic [15:0] v,
      logic [12:0] p, logic [19:0] f, logic e);
    ld = l;
    sm = s;
    vb = b;
    vl = v;
    pl = p;
    fl = f;
    cyc(12);
    note(0, {7'h00, e});
  endtask
  task automatic tk(int n);
    repeat (n) begin
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
      cyc(1);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ********************
  // result watcher
  // ********************
  always @(look) begin : watch
    sec_note_t n;
    n = q.pop_front();
    case (n.id)
      0: check("sync_ok", {7'h00, ok_o}, n.exp);
      1: check("energized_state", {5'h00, st_o}, n.exp);
      2: check("energized_flags", {4'h0, feeder_live_bus_dead, both_sides_live, feeder_dead_bus_live, both_sides_dead}, n.exp);
      3: check("close_pulses", pulses, n.exp);
      4: check("failed_alarm_seen", {7'h00, al_seen}, n.exp);
      5: check("stuck_alarm_seen", {7'h00, st_seen}, n.exp);
      default: check("seq_active", {7'h00, act_o}, n.exp);
    endcase
  end
  initial begin
    #400_000;
    failures++;
    wrap_up();
  end
  initial begin : main
    int kb, kl, r;
    sec_energ_t e;
    logic [15:0] lv [3];
    lv = '{16'h0014, 16'h012c, 16'h03e8};
    cyc(5);
    arst_n_i = 1'b1;
    cyc(3);
    for (int i = 0; i < 16; i++) begin
      kb = $unsigned($random(seed)) % 3;
      kl = $unsigned($random(seed)) % 3;
      r = $random(seed);
      swap = r[0];
      vb = swap ? lv[kl] : lv[kb];
      vl = swap ? lv[kb] : lv[kl];
      e = (kb == 1 || kl == 1) ? EN_UNKNOWN : (kb == 0) ? (kl == 0 ? EN_BOTH_DEAD : EN_FEEDER_LIVE_BUS_DEAD)
        : (kl == 0 ? EN_FEEDER_DEAD_BUS_LIVE : EN_BOTH_SIDES_LIVE);
      cyc(3);
      note(1, {5'h00, e});
      note(2, {4'h0, e == EN_FEEDER_LIVE_BUS_DEAD, e == EN_BOTH_SIDES_LIVE, e == EN_FEEDER_DEAD_BUS_LIVE, e == EN_BOTH_DEAD});
    end
    swap = 1'b0;
    dead_b = 16'h0190;
    vb = 16'h012c;
    vl = v_dead;
    cyc(3);
    note(1, {5'h00, EN_BOTH_DEAD});
    dead_b = 16'h0064;
    $display("energized state test done");
    row(LD_BOTH_DEAD, SM_DISABLE, v_dead, v_dead, 13'h0000, f_nom, 1'b1);
    row(LD_BOTH_DEAD, SM_DISABLE, v_live, v_dead, 13'h0000, f_nom, 1'b0);
    row(LD_LIVE_L_DEAD_B, SM_DISABLE, v_dead, v_live, 13'h0000, f_nom, 1'b1);
    row(LD_LIVE_L_DEAD_B, SM_DISABLE, v_dead, 16'h09c4, 13'h0000, f_nom, 1'b0);
    row(LD_DEAD_L_LIVE_B, SM_DISABLE, v_live, v_dead, 13'h0000, f_nom, 1'b1);
    row(LD_DEAD_B_L_ANY, SM_DISABLE, v_dead, v_dead, 13'h0000, f_nom, 1'b1);
    row(LD_DEAD_L_B_ANY, SM_DISABLE, v_live, v_dead, 13'h0000, f_nom, 1'b1);
    row(LD_ONE_LIVE, SM_DISABLE, v_dead, v_dead, 13'h0000, f_nom, 1'b0);
    row(LD_ONE_LIVE, SM_DISABLE, v_dead, v_live, 13'h0000, f_nom, 1'b1);
    row(LD_NOT_BOTH_LIVE, SM_DISABLE, v_live, v_live, 13'h0000, f_nom, 1'b0);
    row(LD_NOT_BOTH_LIVE, SM_DISABLE, v_dead, v_live, 13'h0000, f_nom, 1'b1);
    row(LD_DISABLE, SM_ASYNC, v_live, v_live, 13'h0000, f_nom, 1'b1);
    row(LD_DISABLE, SM_ASYNC, v_live, 16'h047e, 13'h0000, f_nom, 1'b0);
    row(LD_DISABLE, SM_ASYNC, v_live, v_live, 13'h0096, f_nom, 1'b0);
    row(LD_DISABLE, SM_ASYNC, v_live, v_live, 13'h0000, 20'h0_c418, 1'b0);
    row(LD_DISABLE, SM_ASYNC, 16'h09c4, 16'h09c4, 13'h0000, f_nom, 1'b0);
    row(LD_DISABLE, SM_ASYNC, v_live, 16'h012c, 13'h0000, f_nom, 1'b0);
    row(LD_DISABLE, SM_SYNC, v_live, 16'h03ed, 13'h0000, f_nom, 1'b1);
    row(LD_DISABLE, SM_SYNC, v_live, 16'h0406, 13'h0000, f_nom, 1'b0);
    row(LD_DISABLE, SM_SYNC, v_live, v_live, 13'h0000, 20'h0_c3a0, 1'b0);
    row(LD_DISABLE, SM_SYNC, v_live, v_live, 13'h0050, f_nom, 1'b0);
    row(LD_DISABLE, SM_DISABLE, 16'h012c, 16'h012c, 13'h0000, f_nom, 1'b1);
    $display("permission table test done");
    // manual ticks: a lapse must throw away the two ticks already counted
    tick = 1'b0;
    row(LD_BOTH_DEAD, SM_DISABLE, v_live, v_live, 13'h0000, f_nom, 1'b0);
    vb = v_dead;
    vl = v_dead;
    cyc(2);
    tk(2);
    vb = v_live;
    cyc(2);
    vb = v_dead;
    cyc(2);
    tk(2);
    note(0, 8'h00);
    tk(1);
    cyc(2);
    note(0, 8'h01);
    tick = 1'b1;
    vb = 16'h012c;
    byp = 1'b1;
    cyc(12);
    note(0, 8'h01);
    byp = 1'b0;
    cyc(12);
    note(0, 8'h00);
    $display("timer and bypass test done");
    row(LD_DISABLE, SM_ASYNC, v_live, v_live, 13'h0000, f_nom, 1'b1);
    blk = 1'b1;
    cyc(3);
    note(0, 8'h00);
    note(2, 8'h00);
    blk = 1'b0;
    en = 1'b0;
    cyc(3);
    note(0, 8'h00);
    note(1, {5'h00, EN_UNKNOWN});
    en = 1'b1;
    ce = 1'b0;
    cyc(3);
    note(0, 8'h00);
    ce = 1'b1;
    cyc(2);
    note(0, 8'h01);
    $display("block and enable test done");
    cm = CM_COMMAND;
    cyc(5);
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    cyc(25);
    note(0, 8'h00);
    cyc(25);
    note(3, 8'h01);
    pl = 13'h012c;
    hold = 16'h13ec;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    cyc(60);
    note(3, 8'h00);
    note(4, 8'h01);
    cyc(5120);
    note(5, 8'h01);
    hold = 16'h000a;
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    cyc(5);
    note(6, 8'h01);
    cyc(40);
    note(6, 8'h00);
    note(4, 8'h00);
    $display("command mode test done");
    wrap_up();
  end
endmodule // test_sync_energize_check
`default_nettype wire
